/* hw/cas_seq.sv */
// capacitive-sense auto-scan sequencer with apb registers
`timescale 1ns/1ps
`default_nettype none
module cas_seq #(
  parameter int NUM_CH = 16,
  parameter int CH_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cas_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_done,
  input wire logic conv_gt,
  input wire logic debug_halt,
  input wire logic suspend_mode,
  output logic [CH_W-1:0] chan_sel,
  output logic conv_start,
  output logic [NUM_CH-1:0] pin_ground,
  output logic scan_busy,
  output logic wake_req,
  output logic irq
);

  // masks and read words share one 32-bit word, so wider pin sets cannot be served
  if (NUM_CH < 2 || NUM_CH > 32 || (1 << CH_W) < NUM_CH || CH_W > 5) begin : g_bad_params
    $error("cas_seq: unsupported NUM_CH/CH_W");
  end

  logic [cas_pkg::CFG_W-1:0] cfg_q;
  logic [CH_W-1:0] ss_q;
  logic [CH_W-1:0] se_q;
  logic [CH_W-1:0] mx_q;
  logic [CH_W-1:0] mx_d;
  logic [NUM_CH-1:0] analog_q;
  logic [NUM_CH-1:0] latch_q;
  logic [cas_pkg::IRQ_W-1:0] stat_q;
  logic [cas_pkg::IRQ_W-1:0] stat_d;
  logic [cas_pkg::IRQ_W-1:0] mask_q;
  logic busy_q;
  logic busy_d;
  logic halt_pend_q;
  logic halt_pend_d;
  cas_pkg::cas_state_type state_q;
  cas_pkg::cas_state_type state_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic conv_start_q;
  logic [CH_W-1:0] chan_sel_q;
  logic [NUM_CH-1:0] pin_ground_q;
  logic wake_q;
  logic irq_q;

  // bus decode: zero wait states, read data latched in the setup cycle
  wire setup_ph = psel && !penable;
  wire wr_acc = psel && penable && pready_q && pwrite;
  wire sel_cfg = (paddr == cas_pkg::OFS_CONFIG);
  wire sel_ss = (paddr == cas_pkg::OFS_SCAN_START);
  wire sel_se = (paddr == cas_pkg::OFS_SCAN_END);
  wire sel_mx = (paddr == cas_pkg::OFS_ACTIVE_SEL);
  wire sel_ctrl = (paddr == cas_pkg::OFS_CONTROL);
  wire sel_an = (paddr == cas_pkg::OFS_ANALOG_CFG);
  wire sel_lat = (paddr == cas_pkg::OFS_PORT_LATCH);
  wire sel_stat = (paddr == cas_pkg::OFS_IRQ_STATUS);
  wire sel_mask = (paddr == cas_pkg::OFS_IRQ_MASK);
  wire addr_hit = sel_cfg || sel_ss || sel_se || sel_mx || sel_ctrl || sel_an || sel_lat
                  || sel_stat || sel_mask;
  wire wr_cfg = wr_acc && sel_cfg;
  wire wr_ss = wr_acc && sel_ss;
  wire wr_se = wr_acc && sel_se;
  wire wr_mx = wr_acc && sel_mx;
  wire wr_ctrl = wr_acc && sel_ctrl;
  wire wr_an = wr_acc && sel_an;
  wire wr_lat = wr_acc && sel_lat;
  wire wr_stat = wr_acc && sel_stat;
  wire wr_mask = wr_acc && sel_mask;

  wire [31:0] rd_word =
    sel_cfg ? {25'h0, cfg_q} :
    sel_ss ? {{(32-CH_W){1'b0}}, ss_q} :
    sel_se ? {{(32-CH_W){1'b0}}, se_q} :
    sel_mx ? {{(32-CH_W){1'b0}}, mx_q} :
    sel_ctrl ? {31'h0, busy_q} :
    sel_an ? {{(32-NUM_CH){1'b0}}, analog_q} :
    sel_lat ? {{(32-NUM_CH){1'b0}}, latch_q} :
    sel_stat ? {29'h0, stat_q} :
    sel_mask ? {29'h0, mask_q} : 32'h0;

  // sequencer decode
  wire [cas_pkg::CFG_SOC_W-1:0] soc_src = cfg_q[cas_pkg::CFG_SOC_LSB +: cas_pkg::CFG_SOC_W];
  wire auto_mode = (soc_src == cas_pkg::SOC_AUTOSCAN);
  wire start_req = wr_ctrl && pwdata[cas_pkg::CTRL_BUSY_BIT] && !busy_q;
  wire done_ev = (state_q == cas_pkg::ST_WAIT) && conv_done;
  wire last_conv;
  wire chan_done = done_ev && last_conv;
  wire at_end = (mx_q == se_q);
  wire rot_done = chan_done && auto_mode && at_end;
  // halt only takes effect at the end of a rotation so the scan stays coherent
  wire stop_now = chan_done && (!auto_mode || (at_end && (halt_pend_q || debug_halt)));
  wire in_range = !auto_mode || ((mx_q >= ss_q) && (mx_q <= se_q));
  wire gt_ev = done_ev && conv_gt && in_range;
  wire [CH_W-1:0] next_ch;
  wire [NUM_CH-1:0] sel_onehot = {{(NUM_CH-1){1'b0}}, 1'b1} << mx_d;
  wire [cas_pkg::IRQ_W-1:0] stat_set = {rot_done, gt_ev, chan_done};
  wire [cas_pkg::IRQ_W-1:0] stat_clr = wr_stat ? pwdata[cas_pkg::IRQ_W-1:0] : 3'h0;

  cas_acc_count u_acc (
    .pclk(pclk),
    .presetn(presetn),
    .clear(start_req),
    .step(done_ev),
    .code(cfg_q[cas_pkg::CFG_ACC_LSB +: cas_pkg::CFG_ACC_W]),
    .last(last_conv)
  );

  cas_next_chan #(
    .NUM_CH(NUM_CH),
    .CH_W(CH_W)
  ) u_next (
    .cur(mx_q),
    .last_ch(se_q),
    .analog(analog_q),
    .nxt(next_ch)
  );

  // a bus write to the select wins over an advance in the same cycle
  assign mx_d =
    (wr_ss && auto_mode) ? pwdata[CH_W-1:0] :
    wr_mx ? pwdata[CH_W-1:0] :
    (chan_done && auto_mode && at_end) ? ss_q :
    (chan_done && auto_mode) ? next_ch : mx_q;

  // suspend_mode is deliberately not a term here: scanning keeps running
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      cas_pkg::ST_IDLE: begin
        if (start_req) begin
          state_d = cas_pkg::ST_START;
        end
      end
      cas_pkg::ST_START: begin
        state_d = cas_pkg::ST_WAIT;
      end
      cas_pkg::ST_WAIT: begin
        if (done_ev) begin
          state_d = stop_now ? cas_pkg::ST_IDLE : cas_pkg::ST_START;
        end
      end
      default: begin
        state_d = cas_pkg::ST_IDLE;
      end
    endcase
  end

  assign busy_d = start_req ? 1'b1 : (stop_now ? 1'b0 : busy_q);
  assign halt_pend_d = stop_now ? 1'b0 : (halt_pend_q || (debug_halt && busy_q));
  // set wins over a write-one clear in the same cycle
  assign stat_d = (stat_q & ~stat_clr) | stat_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= cas_pkg::CONFIG_RST;
      ss_q <= '0;
      se_q <= '0;
      analog_q <= '0;
      latch_q <= '0;
      mask_q <= cas_pkg::IRQ_RST;
    end else begin
      if (wr_cfg) begin
        cfg_q <= pwdata[cas_pkg::CFG_W-1:0];
      end
      if (wr_ss) begin
        ss_q <= pwdata[CH_W-1:0];
      end
      if (wr_se) begin
        se_q <= pwdata[CH_W-1:0];
      end
      if (wr_an) begin
        analog_q <= pwdata[NUM_CH-1:0];
      end
      if (wr_lat) begin
        latch_q <= pwdata[NUM_CH-1:0];
      end
      if (wr_mask) begin
        mask_q <= pwdata[cas_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mx_q <= '0;
      state_q <= cas_pkg::ST_IDLE;
      busy_q <= 1'b0;
      halt_pend_q <= 1'b0;
      stat_q <= cas_pkg::IRQ_RST;
    end else begin
      mx_q <= mx_d;
      state_q <= state_d;
      busy_q <= busy_d;
      halt_pend_q <= halt_pend_d;
      stat_q <= stat_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= 1'b1;
      if (setup_ph) begin
        prdata_q <= pwrite ? 32'h0 : rd_word;
        pslverr_q <= !addr_hit;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_start_q <= 1'b0;
      chan_sel_q <= '0;
      pin_ground_q <= '0;
      wake_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      conv_start_q <= (state_d == cas_pkg::ST_START);
      chan_sel_q <= mx_d;
      pin_ground_q <= (state_d != cas_pkg::ST_IDLE) ? (analog_q & ~latch_q & ~sel_onehot)
                                                    : '0;
      wake_q <= suspend_mode && gt_ev;
      irq_q <= |(stat_d & mask_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign chan_sel = chan_sel_q;
  assign conv_start = conv_start_q;
  assign pin_ground = pin_ground_q;
  assign scan_busy = busy_q;
  assign wake_req = wake_q;
  assign irq = irq_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_single_stops: assert property (
    (chan_done && !auto_mode) |=> (state_q == cas_pkg::ST_IDLE) && !scan_busy)
    else $error("non-auto conversion did not stop");

  chk_start_copy: assert property (
    (wr_ss && auto_mode) |=> (mx_q == $past(pwdata[CH_W-1:0])) && (chan_sel == mx_q))
    else $error("start channel not copied to select");

  chk_busy_start: assert property (
    start_req |=> scan_busy && conv_start ##1 !conv_start)
    else $error("busy write did not start conversion");

  chk_advance_next: assert property (
    (chan_done && auto_mode && !at_end && !wr_ss && !wr_mx) |=> (mx_q == $past(next_ch))
      && (mx_q > $past(mx_q)) && conv_start)
    else $error("channel did not advance");

  chk_end_wrap: assert property (
    (rot_done && !wr_ss && !wr_mx) |=> (mx_q == $past(ss_q)))
    else $error("select not reloaded after end");

  chk_pin_ground: assert property (
    (state_q != cas_pkg::ST_IDLE && !$past(wr_an) && !$past(wr_lat))
      |-> (pin_ground == (analog_q & ~latch_q & ~({{(NUM_CH-1){1'b0}}, 1'b1} << mx_q))))
    else $error("ground pattern wrong during conversion");

  chk_halt_finish: assert property (
    (chan_done && auto_mode && !at_end && busy_q) |=> scan_busy)
    else $error("scan stopped mid-rotation");

  chk_halt_stop: assert property (
    (rot_done && halt_pend_q) |=> !scan_busy && (state_q == cas_pkg::ST_IDLE))
    else $error("scan kept running after halted rotation");

  chk_suspend_run: assert property (
    (suspend_mode && busy_q && auto_mode && !stop_now) |=> scan_busy)
    else $error("scan stopped in suspend");

  chk_wake_event: assert property (
    (done_ev && conv_gt && suspend_mode && auto_mode && (mx_q >= ss_q) && (mx_q <= se_q))
      |=> wake_req)
    else $error("wake not raised on in-range event");

  chk_wake_quiet: assert property (
    !(done_ev && conv_gt && suspend_mode) |=> !wake_req)
    else $error("wake raised without a comparator event");

  chk_gt_irq: assert property (
    (gt_ev && mask_q[cas_pkg::IRQ_GT_BIT] && !wr_mask) |=> irq && stat_q[cas_pkg::IRQ_GT_BIT])
    else $error("comparator event did not interrupt");

  chk_acc_hold: assert property (
    (done_ev && !last_conv && !wr_ss && !wr_mx) |=> (mx_q == $past(mx_q)) && conv_start)
    else $error("channel left before accumulation finished");

  chk_range_stay: assert property (
    (chan_done && auto_mode && (mx_q < se_q) && !wr_ss && !wr_mx) |=> (mx_q <= se_q))
    else $error("select ran past the end channel");

  chk_start_any: assert property (
    (rot_done && !halt_pend_q && !debug_halt && !wr_ss && !wr_mx)
      |=> conv_start && (chan_sel == $past(ss_q)))
    else $error("start channel skipped on wrap");

  chk_ground_idle: assert property (
    (state_q == cas_pkg::ST_IDLE) |-> (pin_ground == '0))
    else $error("pins grounded with no conversion");

  chk_irq_level: assert property (
    !$past(wr_mask) |-> (irq == |(stat_q & mask_q)))
    else $error("interrupt level disagrees with status and mask");

endmodule : cas_seq
`default_nettype wire

/* hw/cas_pkg.sv */
// constants, field layout and types of the capacitive-sense auto-scan sequencer
package cas_pkg;

  localparam int PADDR_W = 8;

  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_SCAN_START = 8'h04;
  localparam logic [7:0] OFS_SCAN_END = 8'h08;
  localparam logic [7:0] OFS_ACTIVE_SEL = 8'h0C;
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_ANALOG_CFG = 8'h14;
  localparam logic [7:0] OFS_PORT_LATCH = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

  localparam int CFG_SOC_LSB = 4;
  localparam int CFG_SOC_W = 3;
  localparam int CFG_ACC_LSB = 0;
  localparam int CFG_ACC_W = 3;
  localparam int CFG_W = 7;
  localparam logic [CFG_SOC_W-1:0] SOC_AUTOSCAN = 3'h7;

  localparam int CTRL_BUSY_BIT = 0;

  localparam int IRQ_W = 3;
  localparam int IRQ_CHAN_BIT = 0;
  localparam int IRQ_GT_BIT = 1;
  localparam int IRQ_ROT_BIT = 2;

  localparam logic [CFG_W-1:0] CONFIG_RST = 7'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  localparam int ACC_CNT_W = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_WAIT = 2'b10
  } cas_state_type;

  // conversions per channel: 2 to the power of the accumulator code
  function automatic logic [ACC_CNT_W-1:0] acc_target(input logic [CFG_ACC_W-1:0] code);
    acc_target = 8'h01 << code;
  endfunction : acc_target

endpackage : cas_pkg

/* hw/cas_acc_count.sv */
// counts accumulated conversions on the current channel
`timescale 1ns/1ps
`default_nettype none
module cas_acc_count (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic step,
  input wire logic [cas_pkg::CFG_ACC_W-1:0] code,
  output logic last
);
  logic [cas_pkg::ACC_CNT_W-1:0] cnt_q;
  logic [cas_pkg::ACC_CNT_W-1:0] cnt_d;
  wire [cas_pkg::ACC_CNT_W-1:0] target_m1 = cas_pkg::acc_target(code) - 8'h01;

  assign last = (cnt_q == target_m1);
  assign cnt_d = (clear || (step && last)) ? 8'h00 : (step ? cnt_q + 8'h01 : cnt_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : cas_acc_count
`default_nettype wire

/* hw/cas_next_chan.sv */
// finds the next analog channel after the current one, capped at the end channel
`timescale 1ns/1ps
`default_nettype none
module cas_next_chan #(
  parameter int NUM_CH = 16,
  parameter int CH_W = 4
) (
  input wire logic [CH_W-1:0] cur,
  input wire logic [CH_W-1:0] last_ch,
  input wire logic [NUM_CH-1:0] analog,
  output logic [CH_W-1:0] nxt
);
  if (CH_W < 1 || (1 << CH_W) < NUM_CH) begin : g_bad_params
    $error("cas_next_chan: CH_W too narrow for NUM_CH");
  end

  // descending walk so the lowest qualifying channel wins
  always_comb begin
    nxt = last_ch;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if ((CH_W'(i) > cur) && (CH_W'(i) <= last_ch) && (analog[i] || (CH_W'(i) == last_ch))) begin
        nxt = CH_W'(i);
      end
    end
  end
endmodule : cas_next_chan
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the capacitive-sense auto-scan sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic conv_done = 1'b0;
  logic conv_gt = 1'b0;
  logic debug_halt = 1'b0;
  logic suspend_mode = 1'b0;
  logic [3:0] chan_sel;
  logic conv_start;
  logic [15:0] pin_ground;
  logic scan_busy;
  logic wake_req;
  logic irq;
  int n_mismatch = 0;
  int checked = 0;
  int n_start = 0;
  int n_wake = 0;
  int g1;
  int g2;
  int ns;
  logic [31:0] seed;
  logic [31:0] rd;
  logic err;
  logic [15:0] analog;
  logic [15:0] latch;
  logic [3:0] ss;
  logic [3:0] se;
  logic [2:0] code;

  cas_seq #(.NUM_CH(16), .CH_W(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_done(conv_done), .conv_gt(conv_gt), .debug_halt(debug_halt),
    .suspend_mode(suspend_mode), .chan_sel(chan_sel), .conv_start(conv_start),
    .pin_ground(pin_ground), .scan_busy(scan_busy), .wake_req(wake_req), .irq(irq)
  );

  always #25 pclk = ~pclk;

  // pulses are counted here so that a busy main thread cannot miss them
  always @(posedge pclk) begin
    if (conv_start === 1'b1) n_start++;
    if (wake_req === 1'b1) n_wake++;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // next channel: next analog pin up to the end channel, then back to start
  function automatic logic [3:0] nx(input logic [3:0] c);
    if (c >= se) return ss;
    for (int i = c + 1; i <= se; i++) if (analog[i] || i == se) return 4'(i);
    return ss;
  endfunction : nx

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // plays the converter: one done per start, a few cycles late
  task automatic conv(input logic [3:0] ch, input logic gt);
    int n;
    n = 0;
    do begin @(posedge pclk); n++; end while (conv_start !== 1'b1 && n < 40);
    `CHK("conv_start", 1'b1, conv_start)
    `CHK("chan_sel", ch, chan_sel)
    @(posedge pclk);
    `CHK("pin_ground", analog & ~latch & ~(16'h0001 << ch), pin_ground)
    repeat (xs() % 3) @(posedge pclk);
    conv_done <= 1'b1;
    conv_gt <= gt;
    @(posedge pclk);
    conv_done <= 1'b0;
    conv_gt <= 1'b0;
  endtask : conv

  task automatic rotate(input logic halt, output int gts);
    logic [3:0] ch;
    logic g;
    ch = ss;
    gts = 0;
    do begin
      for (int k = 0; k < (1 << code); k++) begin
        g = 1'(xs() % 2);
        gts += g;
        conv(ch, g);
        debug_halt <= halt;
      end
      ch = nx(ch);
    end while (ch != ss);
  endtask : rotate

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    seed = 32'hAB86B12F;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, cas_pkg::OFS_CONFIG, 32'h0);
    `CHK("config reset", 32'h0, rd)
    apb(1'b0, cas_pkg::OFS_CONTROL, 32'h0);
    `CHK("busy reset", 1'b0, rd[0])
    apb(1'b0, 8'h24, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    $display("test reset done");
    analog = 16'(xs());
    latch = 16'(xs());
    code = 3'(xs() % 2);
    ss = 4'(xs() % 6);
    se = ss + 4'(3 + xs() % 7);
    apb(1'b1, cas_pkg::OFS_ANALOG_CFG, {16'h0, analog});
    apb(1'b1, cas_pkg::OFS_PORT_LATCH, {16'h0, latch});
    apb(1'b1, cas_pkg::OFS_CONFIG, {25'h0, 3'h7, 1'b0, code});
    apb(1'b1, cas_pkg::OFS_SCAN_START, {28'h0, ss});
    apb(1'b1, cas_pkg::OFS_SCAN_END, {28'h0, se});
    apb(1'b0, cas_pkg::OFS_ACTIVE_SEL, 32'h0);
    `CHK("active_sel copy", ss, rd[3:0])
    apb(1'b1, cas_pkg::OFS_IRQ_MASK, 32'h7);
    suspend_mode <= 1'b1;
    apb(1'b1, cas_pkg::OFS_CONTROL, 32'h1);
    rotate(1'b0, g1);
    suspend_mode <= 1'b0;
    rotate(1'b1, g2);
    repeat (3) @(posedge pclk);
    `CHK("wake count", g1, n_wake)
    `CHK("busy after halt", 1'b0, scan_busy)
    `CHK("reload start", ss, chan_sel)
    ns = n_start;
    repeat (10) @(posedge pclk);
    `CHK("starts after halt", ns, n_start)
    apb(1'b0, cas_pkg::OFS_IRQ_STATUS, 32'h0);
    `CHK("status", {1'b1, 1'((g1 + g2) != 0), 1'b1}, rd[2:0])
    `CHK("irq set", 1'b1, irq)
    debug_halt <= 1'b0;
    apb(1'b1, cas_pkg::OFS_IRQ_STATUS, 32'h7);
    @(posedge pclk);
    `CHK("irq clear", 1'b0, irq)
    $display("test auto-scan done");
    apb(1'b1, cas_pkg::OFS_CONFIG, 32'h2);
    apb(1'b1, cas_pkg::OFS_ACTIVE_SEL, 32'h3);
    apb(1'b1, cas_pkg::OFS_SCAN_START, 32'h7);
    apb(1'b0, cas_pkg::OFS_ACTIVE_SEL, 32'h0);
    `CHK("no copy manual", 4'h3, rd[3:0])
    apb(1'b1, cas_pkg::OFS_CONTROL, 32'h1);
    code = 3'h2;
    // a single channel repeated: manual mode must not advance
    for (int k = 0; k < 4; k++) conv(4'h3, 1'b0);
    repeat (3) @(posedge pclk);
    `CHK("manual busy", 1'b0, scan_busy)
    `CHK("manual sel", 4'h3, chan_sel)
    apb(1'b0, cas_pkg::OFS_IRQ_STATUS, 32'h0);
    `CHK("no rotation", 1'b0, rd[2])
    $display("test manual mode done");
    tally_and_finish();
  end
endmodule : tb_top
`undef CHK
`default_nettype wire
